// file: common/gw_codec_pkg.sv
// constants, types and states of the host-side gateway message encoder
// assumes a single synchronous clock domain shared with the card-side link logic
//
// Functional notes
// - status message opens with tag 0x9F8E09, length field, then 8-bit type code.
// - type 0x00 sent when host applications need gateway tunnel data.
// - tunnel request carries 8-bit identifier count, then that many 16-bit identifiers.
// - tunnel request only in advanced mode, never in basic mode.
// - type 0x01 sent once two-way is up; payload is 8-bit upstream channel identifier.
// - type 0x02, no payload, when the modem is forced into one-way operation.
// - type 0x03 after a full downstream scan fails to find its target.
// - type 0x04 before a channel move; payload is 8-bit reinitialization code.
// - after a channel change completes, type 0x01 is sent again.
// - reinitialization codes 0x00 to 0x05 carry the listed meanings.
// - reinitialization codes 0x06 to 0xFF are reserved and never sent.
// - advanced mode forwards whole descriptor, header stripped, after tag and length.
// - after channel change and two-way-up, confirm a valid gateway channel remains.
package gw_codec_pkg;

  localparam logic [23:0] STATUS_TAG      = 24'h9F8E09;
  localparam logic [23:0] DESC_TAG        = 24'h9F8E0B;
  localparam logic [7:0]  TYPE_TUNNEL     = 8'h00;
  localparam logic [7:0]  TYPE_TWO_WAY    = 8'h01;
  localparam logic [7:0]  TYPE_ONE_WAY    = 8'h02;
  localparam logic [7:0]  TYPE_SCAN_DONE  = 8'h03;
  localparam logic [7:0]  TYPE_CHAN_CHG   = 8'h04;
  localparam logic [7:0]  REINIT_MAC      = 8'h00;
  localparam logic [7:0]  REINIT_LAST     = 8'h05;
  localparam logic [7:0]  REINIT_RESERVED = 8'h06;

  // payload sizes in bytes, counted after the length field
  localparam logic [15:0] LEN_NO_ARG      = 16'h0001;
  localparam logic [15:0] LEN_ONE_ARG     = 16'h0002;
  localparam logic [15:0] LEN_TUNNEL_BASE = 16'h0002;

  // length field: short form below the limit, else marker plus two bytes
  localparam logic [15:0] LEN_SHORT_LIMIT = 16'h0080;
  localparam logic [7:0]  LEN_LONG_2B     = 8'h82;
  localparam logic [1:0]  LEN_SHORT_LAST  = 2'h0;
  localparam logic [1:0]  LEN_LONG_LAST   = 2'h2;
  localparam logic [1:0]  TAG_LAST_IDX    = 2'h2;
  localparam logic [1:0]  IDX_FIRST       = 2'h0;
  localparam logic [1:0]  IDX_SECOND      = 2'h1;

  localparam int          APP_SLOTS       = 8;

  typedef enum logic { KIND_STATUS, KIND_DESC } msg_kind_t;

  typedef struct packed {
    msg_kind_t   kind;
    logic [7:0]  msg_type;
    logic [7:0]  arg;
    logic [7:0]  app_count;
    logic [15:0] desc_len;
  } gw_req_t;

  typedef enum {
    ST_IDLE, ST_TAG, ST_LEN, ST_TYPE, ST_COUNT, ST_APP, ST_ARG, ST_DESC
  } enc_state_t;

endpackage : gw_codec_pkg

// file: rtl/gateway_message_codec.sv
// host-side encoder for gateway status messages and forwarded channel descriptors
// assumes the byte sink and all user inputs run on mclk; no pin crosses domains
`timescale 1ns/100ps
module gateway_message_codec
  import gw_codec_pkg::*;
#(
  parameter int MAX_APPS = APP_SLOTS
) (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        mode_advanced,
  input  wire logic                        req_valid,
  input  wire gw_req_t                     req,
  output logic                             req_ready,
  output logic                             req_refused,
  input  wire logic                        app_wr,
  input  wire logic [$clog2(MAX_APPS)-1:0] app_wr_idx,
  input  wire logic [15:0]                 app_identifier,
  input  wire logic                        desc_valid,
  input  wire logic [7:0]                  channel_descriptor_payload,
  output logic                             desc_ready,
  output logic                             tx_valid,
  output logic [7:0]                       tx_data,
  output logic                             tx_last,
  input  wire logic                        tx_ready,
  output logic                             msg_done,
  output logic                             dcc_pending,
  output logic                             channel_check
);

  localparam int AW = $clog2(MAX_APPS);

  ////////////////////////////////////////////////////////////////////////////
  // state and storage

  enc_state_t  state;
  enc_state_t  next_state;
  gw_req_t     cur;
  logic [15:0] pay_len;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic [AW-1:0] app_idx;
  logic [AW-1:0] next_app_idx;
  logic [15:0] desc_left;
  logic [15:0] next_desc_left;
  logic        load;
  logic [7:0]  load_byte;
  logic        load_last;
  logic [15:0] apps [MAX_APPS];

  wire         req_ok;
  wire  [15:0] req_len;
  wire  [1:0]  len_last;
  wire  [7:0]  len_byte;

  gw_request_check #(.MAX_APPS(MAX_APPS)) u_check (
    .mode_advanced (mode_advanced),
    .req           (req),
    .ok            (req_ok),
    .payload_len   (req_len)
  );

  gw_length_encoder u_len (
    .value    (pay_len),
    .idx      (idx),
    .last_idx (len_last),
    .len_byte (len_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // the output slot is free when empty or emptying this cycle
  wire        slot_free  = !tx_valid || tx_ready;
  wire        take       = req_valid && req_ready;
  wire        accept     = take && req_ok;
  wire        desc_take  = desc_valid && desc_ready;
  wire        is_status  = req.kind == KIND_STATUS;
  wire        start_two  = accept && is_status && (req.msg_type == TYPE_TWO_WAY);
  wire        start_chg  = accept && is_status && (req.msg_type == TYPE_CHAN_CHG);
  wire [23:0] tag        = (cur.kind == KIND_DESC) ? DESC_TAG : STATUS_TAG;
  wire [7:0]  tag_byte   = (idx == IDX_FIRST)  ? tag[23:16] :
                           (idx == IDX_SECOND) ? tag[15:8] : tag[7:0];
  wire [15:0] app_word   = apps[app_idx];
  wire [7:0]  app_byte   = (idx == IDX_FIRST) ? app_word[15:8] : app_word[7:0];
  wire        app_final  = (8'(app_idx) + 8'h01) == cur.app_count;
  wire        next_tx_valid = load || (tx_valid && !tx_ready);

  ////////////////////////////////////////////////////////////////////////////
  // byte sequencer: one byte per free output slot, most significant first
  always_comb begin
    next_state     = state;
    next_idx       = idx;
    next_app_idx   = app_idx;
    next_desc_left = desc_left;
    load           = 1'b0;
    load_byte      = 8'h00;
    load_last      = 1'b0;
    case (state)
      ST_IDLE: begin
        next_idx     = IDX_FIRST;
        next_app_idx = '0;
        if (accept) begin
          next_state = ST_TAG;
        end
      end
      ST_TAG: begin
        if (slot_free) begin
          load      = 1'b1;
          load_byte = tag_byte;
          next_idx  = (idx == TAG_LAST_IDX) ? IDX_FIRST : idx + 2'h1;
          if (idx == TAG_LAST_IDX) begin
            next_state = ST_LEN;
          end
        end
      end
      ST_LEN: begin
        if (slot_free) begin
          load      = 1'b1;
          load_byte = len_byte;
          next_idx  = (idx == len_last) ? IDX_FIRST : idx + 2'h1;
          if (idx == len_last) begin
            next_state = (cur.kind == KIND_DESC) ? ST_DESC : ST_TYPE;
          end
        end
      end
      ST_TYPE: begin
        if (slot_free) begin
          load      = 1'b1;
          load_byte = cur.msg_type;
          case (cur.msg_type)
            TYPE_TUNNEL:   next_state = ST_COUNT;
            TYPE_TWO_WAY:  next_state = ST_ARG;
            TYPE_CHAN_CHG: next_state = ST_ARG;
            default: begin
              load_last  = 1'b1;
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_COUNT: begin
        if (slot_free) begin
          load       = 1'b1;
          load_byte  = cur.app_count;
          next_state = ST_APP;
        end
      end
      ST_APP: begin
        if (slot_free) begin
          load      = 1'b1;
          load_byte = app_byte;
          next_idx  = (idx == IDX_FIRST) ? IDX_SECOND : IDX_FIRST;
          if (idx != IDX_FIRST && app_final) begin
            load_last  = 1'b1;
            next_state = ST_IDLE;
          end else if (idx != IDX_FIRST) begin
            next_app_idx = app_idx + AW'(1);
          end
        end
      end
      ST_ARG: begin
        if (slot_free) begin
          load       = 1'b1;
          load_byte  = cur.arg;
          load_last  = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_DESC: begin
        // the output slot is known empty whenever desc_ready is high
        if (desc_take) begin
          load           = 1'b1;
          load_byte      = channel_descriptor_payload;
          next_desc_left = desc_left - 16'h0001;
          if (desc_left == 16'h0001) begin
            load_last  = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (accept) begin
      next_desc_left = req.desc_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      idx       <= IDX_FIRST;
      app_idx   <= '0;
      desc_left <= 16'h0000;
      req_ready <= 1'b0;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      app_idx   <= next_app_idx;
      desc_left <= next_desc_left;
      req_ready <= next_state == ST_IDLE;
    end
  end

  // request capture; held fields stay stable for the whole message
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur     <= '0;
      pay_len <= 16'h0000;
    end else if (accept) begin
      cur     <= req;
      pay_len <= req_len;
    end
  end

  // identifier table; writes only land between messages
  always_ff @(posedge mclk) begin
    if (app_wr && state == ST_IDLE) begin
      apps[app_wr_idx] <= app_identifier;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output byte register; descriptor bytes pass at half rate, no extra buffer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      tx_last    <= 1'b0;
      desc_ready <= 1'b0;
      msg_done   <= 1'b0;
    end else begin
      tx_valid   <= next_tx_valid;
      desc_ready <= (next_state == ST_DESC) && !next_tx_valid;
      msg_done   <= tx_valid && tx_ready && tx_last;
      if (load) begin
        tx_data <= load_byte;
        tx_last <= load_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refusal and channel-change tracking
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req_refused   <= 1'b0;
      dcc_pending   <= 1'b0;
      channel_check <= 1'b0;
    end else begin
      req_refused   <= take && !req_ok;
      channel_check <= start_two && dcc_pending;
      if (start_chg) begin
        dcc_pending <= 1'b1;
      end else if (start_two) begin
        dcc_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_tag_first: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_TAG && idx == IDX_FIRST && slot_free && cur.kind == KIND_STATUS)
    |=> (tx_valid && tx_data == STATUS_TAG[23:16]))
    else $error("status tag first byte wrong");

  chk_basic_tunnel: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && is_status && req.msg_type == TYPE_TUNNEL && !mode_advanced)
    |=> (req_refused && state == ST_IDLE))
    else $error("tunnel request not refused in basic mode");

  chk_reserved_code: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && is_status && req.msg_type == TYPE_CHAN_CHG && req.arg >= REINIT_RESERVED)
    |=> req_refused)
    else $error("reserved reinit code not refused");

  chk_valid_code: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && is_status && req.msg_type == TYPE_CHAN_CHG && req.arg <= REINIT_LAST)
    |=> (!req_refused && dcc_pending && state == ST_TAG))
    else $error("valid reinit code not accepted");

  chk_redo_two_way: assert property (@(posedge mclk) disable iff (sys_rst)
    (start_two && dcc_pending) |=> (channel_check && !dcc_pending) ##1 !channel_check)
    else $error("two-way-up did not close channel change");

  chk_type_byte: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_TYPE && slot_free && cur.msg_type == TYPE_TWO_WAY)
    |=> (tx_data == TYPE_TWO_WAY && !tx_last && state == ST_ARG))
    else $error("two-way type byte or follow-up wrong");

  chk_no_payload: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_TYPE && slot_free && cur.msg_type == TYPE_ONE_WAY)
    |=> (tx_last && tx_valid && state == ST_IDLE))
    else $error("one-way message not ended at type byte");

  chk_tx_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data) && $stable(tx_last)))
    else $error("output byte changed while stalled");

  chk_desc_basic: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && req.kind == KIND_DESC && !mode_advanced) |=> req_refused)
    else $error("descriptor forward accepted in basic mode");

  chk_count_byte: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_COUNT && slot_free) |=> (tx_data == cur.app_count && state == ST_APP))
    else $error("identifier count byte wrong");

endmodule : gateway_message_codec

// file: rtl/gw_length_encoder.sv
// length field encoder: byte selected by index, plus index of the last byte
// assumes the caller walks the index from zero up to last_idx
`timescale 1ns/100ps
module gw_length_encoder
  import gw_codec_pkg::*;
(
  input  wire logic [15:0] value,
  input  wire logic [1:0]  idx,
  output logic      [1:0]  last_idx,
  output logic      [7:0]  len_byte
);

  wire short_form = value < LEN_SHORT_LIMIT;

  // long form is always three bytes so one marker value covers all lengths
  assign last_idx = short_form ? LEN_SHORT_LAST : LEN_LONG_LAST;
  assign len_byte = short_form         ? value[7:0] :
                    (idx == IDX_FIRST)  ? LEN_LONG_2B :
                    (idx == IDX_SECOND) ? value[15:8] : value[7:0];

endmodule : gw_length_encoder

// file: rtl/gw_request_check.sv
// request checker: decides whether a message may be sent and its payload size
// assumes req and mode_advanced are stable while checked in the same cycle
`timescale 1ns/100ps
module gw_request_check
  import gw_codec_pkg::*;
#(
  parameter int MAX_APPS = APP_SLOTS
) (
  input  wire logic        mode_advanced,
  input  wire gw_req_t     req,
  output logic             ok,
  output logic      [15:0] payload_len
);

  localparam logic [7:0] MAX_COUNT = 8'(MAX_APPS);

  wire count_ok  = (req.app_count != 8'h00) && (req.app_count <= MAX_COUNT);
  wire tunnel_ok = mode_advanced && count_ok;
  wire code_ok   = req.arg <= REINIT_LAST;
  wire desc_ok   = mode_advanced && (req.desc_len != 16'h0000);
  wire [15:0] tunnel_len = LEN_TUNNEL_BASE + {7'h00, req.app_count, 1'b0};

  // undefined types never reach the link
  always_comb begin
    ok          = 1'b0;
    payload_len = 16'h0000;
    if (req.kind == KIND_DESC) begin
      ok          = desc_ok;
      payload_len = req.desc_len;
    end else begin
      case (req.msg_type)
        TYPE_TUNNEL: begin
          ok          = tunnel_ok;
          payload_len = tunnel_len;
        end
        TYPE_TWO_WAY: begin
          ok          = 1'b1;
          payload_len = LEN_ONE_ARG;
        end
        TYPE_ONE_WAY, TYPE_SCAN_DONE: begin
          ok          = 1'b1;
          payload_len = LEN_NO_ARG;
        end
        TYPE_CHAN_CHG: begin
          ok          = code_ok;
          payload_len = LEN_ONE_ARG;
        end
        default: begin
          ok          = 1'b0;
          payload_len = 16'h0000;
        end
      endcase
    end
  end

endmodule : gw_request_check

// file: test/card_model.sv
// card-side model: sinks encoded bytes and parses each whole message
// assumes the byte handshake runs on mclk; slow makes it stall every other cycle
`timescale 1ns/100ps
module card_model
  import gw_codec_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       slow,
  input  wire logic       mode_advanced,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] rx[$];
  logic [7:0] msg[$];
  logic [7:0] upstream_channel_identifier = 8'h00;
  int         good = 0;
  int         lookups = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // parse one message; only the short length form is ever sent to this model
  function automatic void parse_msg();
    logic [23:0] tag;
    tag = {msg[0], msg[1], msg[2]};
    if (msg[3] != 8'(msg.size() - 4)) return;
    if (tag == STATUS_TAG) begin
      // basic mode leaves the held upstream id untouched
      if (msg[4] == TYPE_TWO_WAY && mode_advanced) begin
        upstream_channel_identifier = msg[5];
      end
      if (msg[4] == TYPE_TUNNEL) lookups += msg[5];
      good++;
    end else if (tag == DESC_TAG) begin
      good++;
    end
  endfunction : parse_msg

  // stall pattern toggles ready so the encoder must hold its byte
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) tx_ready <= 1'b0;
    else tx_ready <= slow ? !tx_ready : 1'b1;
  end

  // capture consumed bytes, keep a running copy for the bench
  always @(posedge mclk) begin
    if (!sys_rst && tx_valid && tx_ready) begin
      rx.push_back(tx_data);
      msg.push_back(tx_data);
      if (tx_last) begin
        parse_msg();
        msg.delete();
      end
    end
  end
endmodule : card_model

// file: test/tb.sv
// self-checking bench for the host-side gateway message encoder
// assumes card_model as byte sink; expected bytes are built here from the rules
`timescale 1ns/100ps
module tb
  import gw_codec_pkg::*;
;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        mode_advanced = 1'b1;
  logic        req_valid = 1'b0;
  gw_req_t     req = '0;
  logic        req_ready, req_refused, tx_valid, tx_last, tx_ready;
  logic        app_wr = 1'b0;
  logic [2:0]  app_wr_idx = 3'h0;
  logic [15:0] app_identifier = 16'h0000;
  logic        desc_valid = 1'b0;
  logic [7:0]  channel_descriptor_payload = 8'h00;
  logic        desc_ready, msg_done, dcc_pending, channel_check;
  logic [7:0]  tx_data;
  logic        slow = 1'b0;
  logic        saw_check = 1'b0;
  int          miscompares = 0;
  int          compares = 0;

  gateway_message_codec uut (.mclk(mclk), .sys_rst(sys_rst), .mode_advanced(mode_advanced),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .req_refused(req_refused),
    .app_wr(app_wr), .app_wr_idx(app_wr_idx), .app_identifier(app_identifier),
    .desc_valid(desc_valid), .channel_descriptor_payload(channel_descriptor_payload),
    .desc_ready(desc_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .msg_done(msg_done), .dcc_pending(dcc_pending),
    .channel_check(channel_check));
  card_model card (.mclk(mclk), .sys_rst(sys_rst), .slow(slow),
    .mode_advanced(mode_advanced), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));

  // clock and sticky record of the one-cycle confirm pulse
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) if (channel_check === 1'b1) saw_check <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string name, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : cmp

  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // request handshake held until the edge that samples ready high
  task automatic do_req(input msg_kind_t k, input logic [7:0] t, input logic [7:0] a,
                        input logic [7:0] n, input logic [15:0] dl, input logic refuse);
    int w;
    w = 0;
    @(posedge mclk);
    req <= '{kind: k, msg_type: t, arg: a, app_count: n, desc_len: dl};
    req_valid <= 1'b1;
    @(negedge mclk);
    while (req_ready !== 1'b1 && w < 100) begin
      @(negedge mclk);
      w++;
    end
    cmp("req_ready", 8'h01, {7'h0, req_ready});
    @(posedge mclk);
    req_valid <= 1'b0;
    @(negedge mclk);
    cmp("req_refused", {7'h0, refuse}, {7'h0, req_refused});
  endtask : do_req

  // done pulse stands one cycle, so it is looked at every falling edge
  task automatic wait_done();
    int w;
    w = 0;
    while (msg_done !== 1'b1 && w < 200) begin
      @(negedge mclk);
      w++;
    end
    cmp("msg_done", 8'h01, {7'h0, msg_done});
  endtask : wait_done

  task automatic check_rx(input logic [7:0] e[$]);
    cmp("rx_count", 8'(e.size()), 8'(card.rx.size()));
    foreach (e[i]) cmp("rx_byte", e[i], card.rx.size() > i ? card.rx[i] : 8'hXX);
    card.rx.delete();
  endtask : check_rx

  // one descriptor byte; the line shows inverted data once released
  task automatic feed_desc(input logic [7:0] b);
    int w;
    w = 0;
    @(posedge mclk);
    channel_descriptor_payload <= b;
    desc_valid <= 1'b1;
    @(negedge mclk);
    while (desc_ready !== 1'b1 && w < 100) begin
      @(negedge mclk);
      w++;
    end
    cmp("desc_ready", 8'h01, {7'h0, desc_ready});
    @(posedge mclk);
    desc_valid <= 1'b0;
    channel_descriptor_payload <= ~b;
  endtask : feed_desc

  ////////////////////////////////////////////////////////////////////////////////
  task automatic two_way_up();
    do_req(KIND_STATUS, TYPE_TWO_WAY, 8'h5A, 8'h00, 16'h0, 1'b0);
    wait_done();
    check_rx('{8'h9F, 8'h8E, 8'h09, 8'h02, 8'h01, 8'h5A});
    cmp("card_upstream_id", 8'h5A, card.upstream_channel_identifier);
    cmp("channel_check", 8'h00, {7'h0, saw_check});
  endtask : two_way_up

  task automatic tunnel_slow();
    @(posedge mclk);
    app_wr <= 1'b1;
    app_wr_idx <= 3'h0;
    app_identifier <= 16'h1234;
    @(posedge mclk);
    app_wr_idx <= 3'h1;
    app_identifier <= 16'hABCD;
    @(posedge mclk);
    app_wr <= 1'b0;
    slow <= 1'b1;
    do_req(KIND_STATUS, TYPE_TUNNEL, 8'h00, 8'h02, 16'h0, 1'b0);
    wait_done();
    check_rx('{8'h9F, 8'h8E, 8'h09, 8'h06, 8'h00, 8'h02,
               8'h12, 8'h34, 8'hAB, 8'hCD});
    cmp("card_lookups", 8'h02, 8'(card.lookups));
    slow <= 1'b0;
  endtask : tunnel_slow

  task automatic chan_change();
    for (int c = 0; c < 6; c++) begin
      do_req(KIND_STATUS, TYPE_CHAN_CHG, 8'(c), 8'h00, 16'h0, 1'b0);
      wait_done();
      check_rx('{8'h9F, 8'h8E, 8'h09, 8'h02, 8'h04, 8'(c)});
      cmp("dcc_pending", 8'h01, {7'h0, dcc_pending});
    end
    do_req(KIND_STATUS, TYPE_CHAN_CHG, 8'h06, 8'h00, 16'h0, 1'b1);
    do_req(KIND_STATUS, TYPE_CHAN_CHG, 8'hFF, 8'h00, 16'h0, 1'b1);
    do_req(KIND_STATUS, TYPE_TWO_WAY, 8'h33, 8'h00, 16'h0, 1'b0);
    wait_done();
    check_rx('{8'h9F, 8'h8E, 8'h09, 8'h02, 8'h01, 8'h33});
    cmp("card_upstream_id", 8'h33, card.upstream_channel_identifier);
    cmp("channel_check", 8'h01, {7'h0, saw_check});
    cmp("dcc_pending", 8'h00, {7'h0, dcc_pending});
  endtask : chan_change

  task automatic basic_mode();
    @(posedge mclk);
    mode_advanced <= 1'b0;
    do_req(KIND_STATUS, TYPE_TUNNEL, 8'h00, 8'h01, 16'h0, 1'b1);
    do_req(KIND_DESC, 8'h00, 8'h00, 8'h00, 16'h2, 1'b1);
    do_req(KIND_STATUS, TYPE_ONE_WAY, 8'h00, 8'h00, 16'h0, 1'b0);
    wait_done();
    check_rx('{8'h9F, 8'h8E, 8'h09, 8'h01, 8'h02});
    do_req(KIND_STATUS, TYPE_SCAN_DONE, 8'h00, 8'h00, 16'h0, 1'b0);
    wait_done();
    check_rx('{8'h9F, 8'h8E, 8'h09, 8'h01, 8'h03});
    // basic-mode two-way-up must leave the card's upstream id alone
    do_req(KIND_STATUS, TYPE_TWO_WAY, 8'h77, 8'h00, 16'h0, 1'b0);
    wait_done();
    check_rx('{8'h9F, 8'h8E, 8'h09, 8'h02, 8'h01, 8'h77});
    cmp("card_upstream_id", 8'h33, card.upstream_channel_identifier);
    @(posedge mclk);
    mode_advanced <= 1'b1;
  endtask : basic_mode

  task automatic bad_requests();
    do_req(KIND_STATUS, 8'h05, 8'h00, 8'h00, 16'h0, 1'b1);
    do_req(KIND_STATUS, TYPE_TUNNEL, 8'h00, 8'h00, 16'h0, 1'b1);
    do_req(KIND_STATUS, TYPE_TUNNEL, 8'h00, 8'h09, 16'h0, 1'b1);
    do_req(KIND_DESC, 8'h00, 8'h00, 8'h00, 16'h0, 1'b1);
    cmp("rx_count", 8'h00, 8'(card.rx.size()));
  endtask : bad_requests

  task automatic desc_forward();
    do_req(KIND_DESC, 8'h00, 8'h00, 8'h00, 16'h2, 1'b0);
    feed_desc(8'hC1);
    feed_desc(8'hC2);
    wait_done();
    check_rx('{8'h9F, 8'h8E, 8'h0B, 8'h02, 8'hC1, 8'hC2});
  endtask : desc_forward

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    two_way_up();
    tunnel_slow();
    chan_change();
    basic_mode();
    bad_requests();
    desc_forward();
    cmp("card_good", 8'h0D, 8'(card.good));
    report_and_stop();
  end
endmodule : tb
